/* ocs_consts.vh */
/*
 constants for the oscillator master clock select block.
 assumes: included by ocs_top.v and by every other file of the project; no timescale here.
*/
`ifndef OCS_CONSTS_VH
`define OCS_CONSTS_VH
// ****************************************
// frequency table
// ****************************************
`define OCS_SEL_W 5
`define OCS_NUM_FREQ 5'h15
`define OCS_SEL_DEFAULT 5'h00
// nominal frequencies in kHz, index 0..20
`define OCS_KHZ_W 18
`define OCS_F00 18'h0_0820
`define OCS_F01 18'h0_099C
`define OCS_F02 18'h0_0C62
`define OCS_F03 18'h0_10C2
`define OCS_F04 18'h0_15A4
`define OCS_F05 18'h0_1B58
`define OCS_F06 18'h0_2076
`define OCS_F07 18'h0_23D2
`define OCS_F08 18'h0_27F6
`define OCS_F09 18'h0_33F4
`define OCS_F10 18'h0_39BC
`define OCS_F11 18'h0_4FEC
`define OCS_F12 18'h0_67E8
`define OCS_F13 18'h0_7378
`define OCS_F14 18'h0_81E2
`define OCS_F15 18'h0_9470
`define OCS_F16 18'h0_AD2A
`define OCS_F17 18'h0_CFD0
`define OCS_F18 18'h1_03A4
`define OCS_F19 18'h1_5A56
`define OCS_F20 18'h2_0788
// ****************************************
// divider and sync
// ****************************************
`define OCS_DIV_W 8
`define OCS_SYNC_W 3
`define OCS_ONE_DIV 8'h01
`endif

/* ocs_top.v */
/*
 on-chip oscillator control: master clock frequency select, enable and divider.
 assumes: MCLK stands for the free-running oscillator core; the loader presents
 clock configuration bits with a one-cycle strobe; USER_OSC_EN comes from a pin.
*/
// Behaviour
// RULE1 - after power-up and before configuration, run at the 2.08 MHz default.
// RULE2 - switch to the chosen frequency once the clock configuration bits arrive.
// RULE3 - with no frequency chosen, stay at the 2.08 MHz default.
// RULE4 - oscillator turned on or off by a configuration bit and a user input.
// RULE5 - output routable to the global clock tree or as PLL reference.
// RULE6 - output may be divided by internal logic before use.
// RULE7 - only the fixed table of nominal frequencies, 2.08 to 133 MHz, is accepted.
// RULE8 - run only when both enables ask; no truncated pulses on any change. A CFG_ROUTE_PLL change moves GCLK_EN/PLL_REF_EN at once, mid-period.
`timescale 1ns/1ps
`include "ocs_consts.vh"
module ocs_top #(
	parameter DIV_W = `OCS_DIV_W
) (
	input wire MCLK,
	input wire SYS_RST,
	input wire CFG_CLK_STB,
	input wire CFG_CLK_VALID,
	input wire [`OCS_SEL_W-1:0] CFG_CLK_SEL,
	input wire CFG_OSC_EN,
	input wire USER_OSC_EN,
	input wire [DIV_W-1:0] CFG_DIV,
	input wire CFG_ROUTE_PLL,
	output wire [`OCS_SEL_W-1:0] FREQ_SEL,
	output wire [`OCS_KHZ_W-1:0] FREQ_KHZ,
	output wire SEL_REJECT,
	output wire OSC_RUN,
	output wire GCLK_EN,
	output wire PLL_REF_EN,
	output wire OSC_TICK
);
	// ****************************************
	// frequency table lookup
	// ****************************************
	function [`OCS_KHZ_W-1:0] khz_of;
		input [`OCS_SEL_W-1:0] s;
		begin
			case (s)
				5'h00: khz_of = `OCS_F00;
				5'h01: khz_of = `OCS_F01;
				5'h02: khz_of = `OCS_F02;
				5'h03: khz_of = `OCS_F03;
				5'h04: khz_of = `OCS_F04;
				5'h05: khz_of = `OCS_F05;
				5'h06: khz_of = `OCS_F06;
				5'h07: khz_of = `OCS_F07;
				5'h08: khz_of = `OCS_F08;
				5'h09: khz_of = `OCS_F09;
				5'h0A: khz_of = `OCS_F10;
				5'h0B: khz_of = `OCS_F11;
				5'h0C: khz_of = `OCS_F12;
				5'h0D: khz_of = `OCS_F13;
				5'h0E: khz_of = `OCS_F14;
				5'h0F: khz_of = `OCS_F15;
				5'h10: khz_of = `OCS_F16;
				5'h11: khz_of = `OCS_F17;
				5'h12: khz_of = `OCS_F18;
				5'h13: khz_of = `OCS_F19;
				5'h14: khz_of = `OCS_F20;
				default: khz_of = `OCS_F00;
			endcase
		end
	endfunction

	// ****************************************
	// user enable synchroniser
	// ****************************************
	reg [`OCS_SYNC_W-1:0] usr_sync_ff;
	reg usr_en_ff;
	always @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			usr_sync_ff <= {`OCS_SYNC_W{1'b0}};
			usr_en_ff <= 1'b0;
		end else begin
			usr_sync_ff <= {usr_sync_ff[`OCS_SYNC_W-2:0], USER_OSC_EN};
			// change counts only when second and third stages agree
			if (usr_sync_ff[`OCS_SYNC_W-2] == usr_sync_ff[`OCS_SYNC_W-1])
				usr_en_ff <= usr_sync_ff[`OCS_SYNC_W-1];
		end
	end

	// ****************************************
	// frequency selection
	// ****************************************
	reg [`OCS_SEL_W-1:0] sel_ff;
	reg reject_ff;
	wire sel_ok = CFG_CLK_SEL < `OCS_NUM_FREQ;
	always @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sel_ff <= `OCS_SEL_DEFAULT; // RULE1
			reject_ff <= 1'b0;
		end else if (CFG_CLK_STB) begin
			if (!CFG_CLK_VALID)
				sel_ff <= `OCS_SEL_DEFAULT; // RULE3
			else if (sel_ok)
				sel_ff <= CFG_CLK_SEL; // RULE2
			// out-of-table codes leave the current setting untouched
			reject_ff <= CFG_CLK_VALID & ~sel_ok; // RULE7
		end
	end
	assign FREQ_SEL = sel_ff;
	assign FREQ_KHZ = khz_of(sel_ff);
	assign SEL_REJECT = reject_ff;

	// ****************************************
	// enable gate and divider
	// ****************************************
	// new divide value and enables take effect only at a period boundary,
	// so a change never cuts a pulse short
	reg run_ff;
	reg [DIV_W-1:0] div_ff;
	reg [DIV_W-1:0] cnt_ff;
	reg tick_ff;
	wire want_run = CFG_OSC_EN & usr_en_ff; // RULE4
	wire [DIV_W-1:0] div_eff = (CFG_DIV == {DIV_W{1'b0}}) ? `OCS_ONE_DIV : CFG_DIV;
	wire at_end = (cnt_ff == div_ff - `OCS_ONE_DIV);
	always @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			run_ff <= 1'b0;
			div_ff <= `OCS_ONE_DIV;
			cnt_ff <= {DIV_W{1'b0}};
			tick_ff <= 1'b0;
		end else if (!run_ff || at_end) begin
			run_ff <= want_run; // RULE8
			div_ff <= div_eff; // RULE6
			cnt_ff <= {DIV_W{1'b0}};
			tick_ff <= want_run;
		end else begin
			cnt_ff <= cnt_ff + `OCS_ONE_DIV;
			tick_ff <= 1'b0;
		end
	end
	assign OSC_RUN = run_ff;
	assign OSC_TICK = tick_ff & run_ff;
	assign GCLK_EN = run_ff & ~CFG_ROUTE_PLL; // RULE5
	assign PLL_REF_EN = run_ff & CFG_ROUTE_PLL; // RULE5
endmodule // ocs_top

/* ocs_chk.sv */
/* assertions on the oscillator select ports.
 assumes: bound to ocs_top, one clock MCLK. */
`timescale 1ns/1ps
`include "ocs_consts.vh"
module ocs_chk (
	input wire MCLK,
	input wire SYS_RST,
	input wire CFG_CLK_STB,
	input wire CFG_CLK_VALID,
	input wire [`OCS_SEL_W-1:0] CFG_CLK_SEL,
	input wire CFG_OSC_EN,
	input wire CFG_ROUTE_PLL,
	input wire [`OCS_SEL_W-1:0] FREQ_SEL,
	input wire [`OCS_KHZ_W-1:0] FREQ_KHZ,
	input wire SEL_REJECT,
	input wire OSC_RUN,
	input wire GCLK_EN,
	input wire PLL_REF_EN,
	input wire OSC_TICK
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (SYS_RST);
	wire vs = CFG_CLK_STB && CFG_CLK_VALID;
	chk_sel_take: assert property (vs && CFG_CLK_SEL < `OCS_NUM_FREQ |=> FREQ_SEL == $past(CFG_CLK_SEL)) else $error("sel");
	chk_none_dflt: assert property (CFG_CLK_STB && !CFG_CLK_VALID |=> FREQ_SEL == `OCS_SEL_DEFAULT) else $error("dflt");
	chk_sel_refuse: assert property (vs && CFG_CLK_SEL >= `OCS_NUM_FREQ |=> SEL_REJECT && $stable(FREQ_SEL)) else $error("rej");
	chk_sel_hold: assert property (!CFG_CLK_STB |=> $stable(FREQ_SEL) && $stable(SEL_REJECT)) else $error("hold");
	chk_dflt_khz: assert property (FREQ_SEL == `OCS_SEL_DEFAULT |-> FREQ_KHZ == `OCS_F00) else $error("khz");
	chk_route_mux: assert property (GCLK_EN == (OSC_RUN && !CFG_ROUTE_PLL) && PLL_REF_EN == (OSC_RUN && CFG_ROUTE_PLL)) else $error("route");
	chk_run_start: assert property ($rose(OSC_RUN) |-> $past(CFG_OSC_EN) && OSC_TICK) else $error("start");
	chk_tick_run: assert property (OSC_TICK |-> OSC_RUN) else $error("tick");
	// five cycles covers a latched divide of up to four
	chk_off_stop: assert property (!CFG_OSC_EN [*5] |-> !OSC_RUN) else $error("stop");
endmodule // ocs_chk
bind ocs_top ocs_chk u_chk (.MCLK, .SYS_RST, .CFG_CLK_STB, .CFG_CLK_VALID, .CFG_CLK_SEL, .CFG_OSC_EN,
	.CFG_ROUTE_PLL, .FREQ_SEL, .FREQ_KHZ, .SEL_REJECT, .OSC_RUN, .GCLK_EN, .PLL_REF_EN, .OSC_TICK);

/* ocs_ldr.sv */
/* loader model: clock config bits with a one-cycle strobe.
 assumes: tb calls send; MCLK shared. */
`timescale 1ns/1ps
`include "ocs_consts.vh"
module ocs_ldr (
	input wire mclk,
	output logic stb = 1'h0,
	output logic valid = 1'h0,
	output logic [`OCS_SEL_W-1:0] sel = 5'h00
);
	task send(input logic v, input logic [`OCS_SEL_W-1:0] s, input int slow);
		repeat (slow + 1) @(posedge mclk);
		stb <= 1'h1;
		valid <= v;
		sel <= s;
		@(posedge mclk);
		// bits are stale once the strobe drops, so show their inverse
		stb <= 1'h0;
		valid <= ~v;
		sel <= ~s;
	endtask
endmodule // ocs_ldr

/* tb.sv */
/* self-checking bench for ocs_top.
 assumes: ocs_ldr and ocs_chk compiled first. */
`timescale 1ns/1ps
`include "ocs_consts.vh"
module tb;
	logic mclk, rst, oen, uen, route, seen, v;
	logic [7:0] div;
	logic [4:0] s, cur;
	logic [5:0] q[$];
	wire stb, valid, rej, run, gclk, pref, tick;
	wire [4:0] sel, fsel;
	wire [17:0] khz;
	int n_mismatch = 0, checks_done = 0, i, n;
	ocs_top u_dut (.MCLK(mclk), .SYS_RST(rst), .CFG_CLK_STB(stb), .CFG_CLK_VALID(valid), .CFG_CLK_SEL(sel),
		.CFG_OSC_EN(oen), .USER_OSC_EN(uen), .CFG_DIV(div), .CFG_ROUTE_PLL(route), .FREQ_SEL(fsel),
		.FREQ_KHZ(khz), .SEL_REJECT(rej), .OSC_RUN(run), .GCLK_EN(gclk), .PLL_REF_EN(pref), .OSC_TICK(tick));
	ocs_ldr u_ldr (.mclk(mclk), .stb(stb), .valid(valid), .sel(sel));
	task chk(input logic [23:0] got, input logic [23:0] want);
		checks_done++;
		if (got !== want) begin
			n_mismatch++;
			$display("Error t=%0t got %h exp %h", $time, got, want);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		#200000;
		n_mismatch++;
		print_verdict;
	end
	always @(posedge mclk) begin
		seen <= stb;
		if (seen) chk({rej, fsel}, q.pop_front());
	end
	initial begin
		{rst, oen, uen, route, cur, div} = {1'h1, 8'h00, 8'h03};
		void'($urandom(61362));
		repeat (6) @(posedge mclk);
		rst <= 1'h0;
		@(posedge mclk);
		chk({run, fsel, khz}, {1'h0, `OCS_SEL_DEFAULT, `OCS_F00});
		$display("test reset done");
		for (i = 0; i < 54; i++) begin
			v = (i < 32) ? 1'h1 : (i < 34) ? 1'h0 : $urandom;
			s = (i < 34) ? i[4:0] : $urandom;
			if (!v) cur = `OCS_SEL_DEFAULT;
			else if (s < `OCS_NUM_FREQ) cur = s;
			q.push_back({v && s >= `OCS_NUM_FREQ, cur});
			{oen, uen, route} <= $urandom;
			div <= $urandom % 4;
			u_ldr.send(v, s, $urandom % 2);
		end
		repeat (2) @(posedge mclk);
		$display("test select done");
		{oen, uen, route, div} <= {3'h7, 8'h03};
		repeat (12) @(posedge mclk);
		n = 0;
		repeat (9) @(posedge mclk) n += tick;
		chk({run, pref, gclk, n[3:0]}, {3'h6, 4'h3});
		uen <= 1'h0;
		repeat (12) @(posedge mclk);
		chk({run, tick}, 2'h0);
		$display("test run done");
		print_verdict;
	end
endmodule // tb
